// ===== core/amvd_defines.vh
// address map and vector table constants for the address decoder
`ifndef AMVD_DEFINES_VH
`define AMVD_DEFINES_VH
// region bases (24-bit cpu addresses)
`define AMVD_DMA_BASE 24'h000100
`define AMVD_RES0_BASE 24'h0000f0
`define AMVD_GPR_BASE 24'h000180
`define AMVD_PERI1_BASE 24'h000380
`define AMVD_RES1_BASE 24'h000c00
`define AMVD_RAM0_BASE 24'h007200
`define AMVD_RAM0_SIZE 24'h001000
`define AMVD_MIRROR_BASE 24'h008000
`define AMVD_RES2_BASE 24'h010000
`define AMVD_PERI2_BASE 24'h0e9000
`define AMVD_BOOT_BASE 24'h0fc000
`define AMVD_BOOT_END 24'h100000
// flash banks
`define AMVD_BANK_FF 8'hff
`define AMVD_BANK_FE 8'hfe
`define AMVD_BANK_DF 8'hdf
`define AMVD_BANK_3F 8'h3f
`define AMVD_BANK_3E 8'h3e
`define AMVD_BANK_1F 8'h1f
`define AMVD_SAS_END 16'h2000
`define AMVD_SAS_MASK 16'h01ff
`define AMVD_SECT_END 16'ha000
// vector table
`define AMVD_VEC_TOP 10'h3fc
`define AMVD_VEC_MAX 8'h8f
`define AMVD_VEC_RESET 8'h08
`define AMVD_VEC_NMI 8'h0b
`define AMVD_VEC_ICR_FIRST 8'h0c
`define AMVD_VEC_CAN 8'h21
`define AMVD_VEC_LIN_FIRST 8'h65
`define AMVD_VEC_LIN_LAST 8'h68
`define AMVD_VEC_FLASH 8'h85
`define AMVD_VEC_ADC_RC 8'h8b
`define AMVD_VEC_ADC_PD 8'h8c
// region codes
`define AMVD_REG_NONE 4'h0
`define AMVD_REG_PERI0 4'h1
`define AMVD_REG_DMA 4'h2
`define AMVD_REG_GPR 4'h3
`define AMVD_REG_PERI1 4'h4
`define AMVD_REG_RAM0 4'h5
`define AMVD_REG_MIRROR 4'h6
`define AMVD_REG_PERI2 4'h7
`define AMVD_REG_BOOT 4'h8
`define AMVD_REG_FLASH 4'h9
`define AMVD_REG_SAS 4'ha
`endif

// ===== core/amvd_decode.v
// address region decoder and interrupt vector table lookup
`timescale 1ns/100ps
`default_nettype none
`include "amvd_defines.vh"
module amvd_decode #(
   parameter HAS_DMA = 1,
   parameter GPR_WORDS = 64
) (
   input wire clk, // system clock
   input wire nrst, // synchronous reset, active low
   input wire [23:0] addr, // cpu address
   input wire rd, // read strobe
   input wire wr, // write strobe
   input wire [15:0] wdata, // write data
   input wire [15:0] gpr_used, // one bit per register bank in use
   input wire flash_prog_mode, // device is in flash programming mode
   input wire operating_mode_pin, // mode pin, raw
   input wire debug_if_pin, // debug interface pin, raw
   input wire [7:0] vec_num, // vector number to look up
   output reg [3:0] region_q, // selected region code
   output reg [23:0] phys_addr_q, // physical address after aliasing
   output reg flash_sel_q, // user flash selected
   output reg rom_configuration_block_q, // configuration block selected
   output reg eeprom_emul_ok_q, // flash address usable for eeprom emulation
   output reg [15:0] rdata_q, // register bank read data, zero elsewhere
   output reg [23:0] vec_addr_q, // vector table address
   output reg vec_valid_q, // vector has a request source
   output reg vec_dma_clr_q, // vector clearable by dma
   output reg vec_has_icr_q, // vector has an icr index
   output reg [7:0] interrupt_control_register_index_q, // icr index
   output reg serial_prog_q // serial flash programming entry condition
);
   // ************************************************************
   // notes
   // ************************************************************
   // every output but serial_prog_q is a flop fed from this cycle's inputs, so each answer
   // appears one edge after its request and stands for a single cycle.
   // requests may come back to back; nothing here holds state across
   // requests except the register bank words and the pin synchronisers.
   // ram bank 0 ends inside the mirror window; the ram test comes first,
   // so the overlapping words belong to ram.
   // banks fe and 3e are treated as flash like ff and 3f; addresses above
   // the last small sector in bank df select nothing.
   // the small configuration sector repeats every 512 bytes up to the
   // first small flash sector, so only the low nine offset bits reach it.
   // the dma window is a parameter: a variant without the controller
   // decodes it as reserved and returns zero on reads.
   // the mode pins are raw board levels and pass two flops before use;
   // both flops reset high so a fresh reset never looks like an entry.
   // reserved vectors report no source and no dma clear, whatever their
   // neighbours do; a handler table entry there is never requested.

   // ************************************************************
   // functions
   // ************************************************************
   // true when a lies in the half-open window from lo up to hi
   function in_range;
      input [23:0] a;
      input [23:0] lo;
      input [23:0] hi;
      begin
         in_range = (a >= lo) && (a < hi);
      end
   endfunction

   // control index of a vector; the core vectors below the first one have none
   function [7:0] icr_of;
      input [7:0] n;
      begin
         icr_of = 8'h00;
         if (n >= `AMVD_VEC_ICR_FIRST)
            icr_of = n;
      end
   endfunction

   // region code for an address
   function [3:0] region_of;
      input [23:0] a;
      input pm;
      begin
         region_of = `AMVD_REG_NONE;
         if (pm) begin
            if (a[23:16] == `AMVD_BANK_3F || a[23:16] == `AMVD_BANK_3E)
               region_of = `AMVD_REG_FLASH;
            else if (a[23:16] == `AMVD_BANK_1F && a[15:0] < `AMVD_SAS_END)
               region_of = `AMVD_REG_SAS;
            else if (a[23:16] == `AMVD_BANK_1F && a[15:0] < `AMVD_SECT_END)
               region_of = `AMVD_REG_FLASH;
         end else if (a[23:16] == `AMVD_BANK_FF || a[23:16] == `AMVD_BANK_FE)
            region_of = `AMVD_REG_FLASH;
         else if (a[23:16] == `AMVD_BANK_DF && a[15:0] < `AMVD_SAS_END)
            region_of = `AMVD_REG_SAS;
         else if (a[23:16] == `AMVD_BANK_DF && a[15:0] < `AMVD_SECT_END)
            region_of = `AMVD_REG_FLASH;
         else if (a < `AMVD_RES0_BASE)
            region_of = `AMVD_REG_PERI0;
         else if (a < `AMVD_DMA_BASE)
            region_of = `AMVD_REG_NONE;
         else if (a < `AMVD_GPR_BASE)
            region_of = (HAS_DMA != 0) ? `AMVD_REG_DMA : `AMVD_REG_NONE;
         else if (a < `AMVD_PERI1_BASE)
            region_of = `AMVD_REG_GPR;
         else if (a < `AMVD_RES1_BASE)
            region_of = `AMVD_REG_PERI1;
         else if (in_range(a, `AMVD_RAM0_BASE, `AMVD_RAM0_BASE + `AMVD_RAM0_SIZE))
            region_of = `AMVD_REG_RAM0;
         else if (in_range(a, `AMVD_MIRROR_BASE, `AMVD_RES2_BASE))
            region_of = `AMVD_REG_MIRROR;
         else if (in_range(a, `AMVD_PERI2_BASE, `AMVD_BOOT_BASE))
            region_of = `AMVD_REG_PERI2;
         else if (in_range(a, `AMVD_BOOT_BASE, `AMVD_BOOT_END))
            region_of = `AMVD_REG_BOOT;
      end
   endfunction

   // vector has a request source; anything not listed is reserved
   function vec_src;
      input [7:0] n;
      begin
         vec_src = 1'b0;
         case (n)
            8'h00, 8'h01, 8'h02, 8'h03,
            8'h04, 8'h05, 8'h06, 8'h07: vec_src = 1'b1;
            `AMVD_VEC_RESET: vec_src = 1'b1;
            8'h09, 8'h0a: vec_src = 1'b1;
            `AMVD_VEC_NMI: vec_src = 1'b1;
            `AMVD_VEC_ICR_FIRST: vec_src = 1'b1;
            8'h0d, 8'h0e, 8'h0f: vec_src = 1'b1; // rc, main and sub clock timers
            8'h10: vec_src = 1'b1; // low voltage detector
            8'h11, 8'h12, 8'h13, 8'h14, 8'h15: vec_src = 1'b1;
            8'h17, 8'h18: vec_src = 1'b1;
            `AMVD_VEC_CAN: vec_src = 1'b1;
            8'h26, 8'h27, 8'h28, 8'h29: vec_src = 1'b1; // pulse generators
            8'h3b, 8'h3c, 8'h40: vec_src = 1'b1; // reload timers
            8'h41, 8'h42, 8'h45, 8'h46: vec_src = 1'b1; // capture units
            8'h59, 8'h5a: vec_src = 1'b1; // free running timers
            8'h5d, 8'h5e, 8'h5f: vec_src = 1'b1; // clock, calibration, sound
            8'h60, 8'h62: vec_src = 1'b1; // two wire interface, converter
            8'h65, 8'h66, 8'h67, 8'h68: vec_src = 1'b1;
            `AMVD_VEC_FLASH: vec_src = 1'b1;
            `AMVD_VEC_ADC_RC, `AMVD_VEC_ADC_PD: vec_src = 1'b1;
            default: vec_src = 1'b0;
         endcase
      end
   endfunction

   // vector clearable by dma; core and reserved vectors never are
   function vec_dma;
      input [7:0] n;
      begin
         vec_dma = 1'b0;
         case (n)
            8'h11, 8'h12, 8'h13, 8'h14, 8'h15: vec_dma = 1'b1;
            8'h17, 8'h18: vec_dma = 1'b1;
            8'h26, 8'h27, 8'h28, 8'h29: vec_dma = 1'b1; // pulse generators
            8'h3b, 8'h3c, 8'h40: vec_dma = 1'b1; // reload timers
            8'h41, 8'h42, 8'h45, 8'h46: vec_dma = 1'b1; // capture units
            8'h59, 8'h5a: vec_dma = 1'b1; // free running timers
            8'h60, 8'h62: vec_dma = 1'b1; // two wire interface, converter
            8'h65, 8'h66, 8'h67, 8'h68: vec_dma = 1'b1;
            `AMVD_VEC_FLASH: vec_dma = 1'b1;
            `AMVD_VEC_CAN: vec_dma = 1'b0;
            `AMVD_VEC_ADC_RC, `AMVD_VEC_ADC_PD: vec_dma = 1'b0;
            default: vec_dma = 1'b0;
         endcase
      end
   endfunction

   // ************************************************************
   // register bank storage
   // ************************************************************
   reg [15:0] gpr_mem [0:GPR_WORDS-1];
   wire [3:0] region_d = region_of(addr, flash_prog_mode);
   wire [5:0] gpr_idx = addr[6:1];
   wire gpr_hit = (region_d == `AMVD_REG_GPR);

   // unused banks act as ram, used banks still store cpu writes
   always @(posedge clk) begin
      if (wr && gpr_hit)
         gpr_mem[gpr_idx] <= wdata;
   end

   // ************************************************************
   // mode pin synchronisers
   // ************************************************************
   reg [1:0] md_sync_q;
   reg [1:0] dbg_sync_q;
   always @(posedge clk) begin
      if (!nrst) begin
         md_sync_q <= 2'h3;
         dbg_sync_q <= 2'h3;
      end else begin
         md_sync_q <= {md_sync_q[0], operating_mode_pin};
         dbg_sync_q <= {dbg_sync_q[0], debug_if_pin};
      end
   end

   // ************************************************************
   // registered decode outputs
   // ************************************************************
   reg [23:0] phys_d;
   always @* begin
      phys_d = addr;
      if (region_d == `AMVD_REG_SAS)
         phys_d = {addr[23:16], addr[15:0] & `AMVD_SAS_MASK};
   end

   // region code, aliased address and memory select flags
   always @(posedge clk) begin
      if (!nrst) begin
         region_q <= `AMVD_REG_NONE;
         phys_addr_q <= 24'h000000;
         flash_sel_q <= 1'b0;
         rom_configuration_block_q <= 1'b0;
         eeprom_emul_ok_q <= 1'b0;
      end else begin
         region_q <= region_d;
         phys_addr_q <= phys_d;
         flash_sel_q <= (region_d == `AMVD_REG_FLASH) || (region_d == `AMVD_REG_SAS);
         rom_configuration_block_q <= (region_d == `AMVD_REG_SAS);
         eeprom_emul_ok_q <= (region_d == `AMVD_REG_FLASH);
      end
   end

   // read data, zero outside the register banks so stale words never leak
   always @(posedge clk) begin
      if (!nrst) begin
         rdata_q <= 16'h0000;
      end else begin
         rdata_q <= (rd && gpr_hit) ? gpr_mem[gpr_idx] : 16'h0000;
      end
   end

   // serial programming entry condition from the synchronised pins
   always @(posedge clk) begin
      if (!nrst) begin
         serial_prog_q <= 1'b0;
      end else begin
         serial_prog_q <= !md_sync_q[1] && !dbg_sync_q[1];
      end
   end

   // ************************************************************
   // vector table lookup
   // ************************************************************
   // vector table address; the table grows downward from its top entry
   always @(posedge clk) begin
      if (!nrst) begin
         vec_addr_q <= 24'h000000;
      end else begin
         vec_addr_q <= {14'h0000, `AMVD_VEC_TOP - {vec_num, 2'b00}};
      end
   end

   // vector attributes: source, dma clear and control index
   always @(posedge clk) begin
      if (!nrst) begin
         vec_valid_q <= 1'b0;
         vec_dma_clr_q <= 1'b0;
         vec_has_icr_q <= 1'b0;
         interrupt_control_register_index_q <= 8'h00;
      end else begin
         vec_valid_q <= vec_src(vec_num);
         vec_dma_clr_q <= vec_dma(vec_num) && vec_src(vec_num);
         vec_has_icr_q <= (vec_num >= `AMVD_VEC_ICR_FIRST) && vec_src(vec_num);
         interrupt_control_register_index_q <= icr_of(vec_num);
      end
   end

   // unused bank mask is advisory; banks in use still hold register contents
   wire unused_ok = |gpr_used;
endmodule // amvd_decode
`default_nettype wire

// ===== testbench/amvd_cpu_model.sv
// behavioural cpu core model issuing one request per cycle
`timescale 1ns/100ps
`default_nettype none
module amvd_cpu_model (
   input wire logic clk, // system clock
   output var logic [23:0] addr, // cpu address
   output var logic rd, // read strobe
   output var logic wr, // write strobe
   output var logic [15:0] wdata, // write data
   output var logic [7:0] vec_num // vector number
);
   // idle bus at time zero
   initial begin
      {addr, rd, wr, wdata, vec_num} = 50'h0;
   end
   // launch just after the falling edge so the sampling edge sees settled values
   task automatic issue(input logic [23:0] a, input logic r, input logic w,
      input logic [15:0] d, input logic [7:0] v);
      @(negedge clk);
      addr = a;
      rd = r;
      wr = w;
      wdata = w ? d : ~wdata; // data bus is not held outside writes
      vec_num = v;
   endtask
endmodule // amvd_cpu_model
`default_nettype wire

// ===== testbench/amvd_decode_props.sv
// assertion checker for the address decoder
`timescale 1ns/100ps
`default_nettype none
module amvd_decode_props #(parameter HAS_DMA = 1, parameter GPR_WORDS = 64) (
   input wire clk, // clock
   input wire nrst, // reset
   input wire [23:0] addr, // address
   input wire rd, // read
   input wire wr, // write
   input wire [15:0] wdata, // write data
   input wire flash_prog_mode, // programming view
   input wire operating_mode_pin, // mode pin
   input wire debug_if_pin, // debug pin
   input wire [7:0] vec_num, // vector number
   input wire [3:0] region_q, // region
   input wire [23:0] phys_addr_q, // physical address
   input wire [15:0] rdata_q, // read data
   input wire [23:0] vec_addr_q, // vector address
   input wire vec_has_icr_q, // has index
   input wire [7:0] interrupt_control_register_index_q, // index
   input wire serial_prog_q // serial entry
);
   default clocking dc @(posedge clk); endclocking
   default disable iff (!nrst);
   AST_VEC_ADDR: assert property ($past(nrst) |->
      vec_addr_q == 24'h0003fc - {14'h0, $past(vec_num), 2'b00}) else $error("bad vector address");
   AST_CTRL_IDX: assert property ($past(nrst) |-> interrupt_control_register_index_q ==
      ($past(vec_num) >= 8'h0c ? $past(vec_num) : 8'h00)) else $error("bad control index");
   AST_LOW_VEC: assert property ($past(nrst && vec_num < 8'h0c) |-> !vec_has_icr_q)
      else $error("low vector has index");
   AST_RESET: assert property ($past(!nrst) |-> region_q == 4'h0 && !serial_prog_q)
      else $error("output active after reset");
   AST_CFG: assert property ($past(nrst && !flash_prog_mode && addr[23:13] == 11'h6f8) |->
      region_q == 4'ha && phys_addr_q == {15'h6f80, $past(addr[8:0])}) else $error("bad alias");
   AST_DMA: assert property ($past(nrst && addr[23:7] == 17'h00002) |->
      region_q == (HAS_DMA != 0 ? 4'h2 : 4'h0)) else $error("bad dma region");
   AST_RES_ZERO: assert property ($past(nrst && addr >= 24'h000c00 && addr < 24'h007200) |->
      region_q == 4'h0 && rdata_q == 16'h0000) else $error("reserved region selected");
   AST_BANK_RB: assert property ((wr && !rd && addr >= 24'h000180 && addr < 24'h000380)
      ##1 (rd && !wr && $stable(addr)) |=> rdata_q == $past(wdata, 2)) else $error("bad readback");
   AST_SERIAL: assert property ((!operating_mode_pin && !debug_if_pin)[*4] |=> serial_prog_q)
      else $error("serial entry missed");
endmodule // amvd_decode_props
bind amvd_decode amvd_decode_props #(.HAS_DMA(HAS_DMA), .GPR_WORDS(GPR_WORDS)) amvd_decode_props_inst (.*);
`default_nettype wire

// ===== testbench/amvd_decode_tb.sv
// self-checking bench for the address decoder
`timescale 1ns/100ps
`default_nettype none
module amvd_decode_tb;
   typedef struct {logic [3:0] r; logic [23:0] p; logic [15:0] d; logic [23:0] va;
      logic [7:0] ix; logic [5:0] f; logic sc; logic s;} amvd_note_t;
   logic clk, nrst, flash_prog_mode, operating_mode_pin, debug_if_pin;
   logic [15:0] gpr_used = 16'h0000; // advisory input
   wire [23:0] addr, phys_addr_q, vec_addr_q;
   wire [15:0] wdata, rdata_q;
   wire [7:0] vec_num, interrupt_control_register_index_q;
   wire [3:0] region_q;
   wire rd, wr, flash_sel_q, rom_configuration_block_q, eeprom_emul_ok_q, vec_valid_q;
   wire vec_dma_clr_q, vec_has_icr_q, serial_prog_q;
   logic [23:0] base [12] = '{24'h100000, 24'h0fc000, 24'h0e9000, 24'h010000, 24'h008000,
      24'h007200, 24'h000c00, 24'h000380, 24'h000180, 24'h000100, 24'h0000f0, 24'h000000};
   logic [3:0] code [12] = '{4'h0, 4'h8, 4'h7, 4'h0, 4'h6, 4'h5, 4'h0, 4'h4, 4'h3, 4'h2, 4'h0, 4'h1};
   logic [7:0] bank [6] = '{8'h00, 8'h0e, 8'h0f, 8'hdf, 8'hff, 8'hfe};
   logic [23:0] pm_a [6] = '{24'h3f1234, 24'h3e0000, 24'h1f0100, 24'h1f1e02, 24'h1f2000, 24'h1fa000};
   logic [15:0] mem [64];
   amvd_note_t q [$];
   int error_cnt = 0, checks = 0, age = 0;
   amvd_decode #(.HAS_DMA(1), .GPR_WORDS(64)) amvd_decode_inst (.*);
   amvd_cpu_model amvd_cpu_model_inst (.*);
   // expected region from the address map
   function automatic logic [3:0] exp_reg(input logic [23:0] a);
      logic [7:0] hi = flash_prog_mode ? 8'h3f : 8'hff;
      if (a[23:16] == hi || a[23:16] == (hi ^ 8'h01)) return 4'h9;
      if (a[23:16] == (hi ^ 8'h20)) return a[15:13] == 3'h0 ? 4'ha : (a[15:0] < 16'ha000 ? 4'h9 : 4'h0);
      for (int i = 0; i < 12; i++) if (a >= base[i]) return code[i];
      return 4'h0;
   endfunction
   // request source and dma clear per vector
   function automatic logic [1:0] src(input logic [7:0] n);
      case (n)
         17, 18, 19, 20, 21, 23, 24, 38, 39, 40, 41, 59, 60, 64, 65, 66, 69, 70, 89, 90, 96, 98,
            101, 102, 103, 104, 133: return 2'b11;
         33, 93, 94, 95, 139, 140: return 2'b10;
         default: return {n < 8'h11, 1'b0};
      endcase
   endfunction
   task automatic cmp(input string nm, input logic [23:0] e, input logic [23:0] g);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   // drive one request and note its expected result
   task automatic step(input logic [23:0] a, input logic r, input logic w, input logic [7:0] v);
      amvd_note_t n;
      logic [15:0] d = 16'($urandom);
      if (a[23:9] == 15'h0040) a[9] = 1'b1; // keep clear of the ram and mirror overlap
      n.r = exp_reg(a);
      n.p = n.r == 4'ha ? {a[23:16], 7'h00, a[8:0]} : a;
      n.d = r && n.r == 4'h3 ? mem[a[6:1]] : 16'h0000;
      n.va = 24'h0003fc - {14'h0, v, 2'b00};
      n.ix = v >= 8'h0c ? v : 8'h00;
      n.f = {src(v), 1'b0, n.r == 4'h9 || n.r == 4'ha, n.r == 4'ha, n.r == 4'h9};
      n.f[3] = n.f[5] && v >= 8'h0c;
      age++;
      n.sc = age > 4;
      n.s = !operating_mode_pin && !debug_if_pin;
      if (w && n.r == 4'h3) mem[a[6:1]] = d;
      amvd_cpu_model_inst.issue(a, r, w, d, v);
      q.push_back(n);
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // compare the oldest note once the result has landed
   always @(posedge clk) begin
      amvd_note_t n;
      #1;
      if (q.size() > 0) begin
         n = q.pop_front();
         cmp("region", n.r, region_q);
         cmp("phys", n.p, phys_addr_q);
         cmp("rdata", n.d, rdata_q);
         cmp("vaddr", n.va, vec_addr_q);
         cmp("index", n.ix, interrupt_control_register_index_q);
         cmp("vflags", n.f[5:3], {vec_valid_q, vec_dma_clr_q, vec_has_icr_q});
         cmp("mflags", n.f[2:0], {flash_sel_q, rom_configuration_block_q, eeprom_emul_ok_q});
         if (n.sc) cmp("serial", n.s, serial_prog_q);
      end
   end
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // watchdog
   initial begin
      #60000;
      error_cnt++;
      end_of_test;
   end
   // main sequence
   initial begin
      logic [23:0] a;
      int k;
      {nrst, flash_prog_mode, operating_mode_pin, debug_if_pin} = 4'h0;
      void'($urandom(32'ha968));
      repeat (8) @(posedge clk);
      @(negedge clk);
      cmp("reset", 24'h0, {region_q, vec_addr_q[19:0]});
      nrst = 1'b1;
      for (int v = 0; v < 144; v++) step(base[v % 12] - 24'(v / 72), 1'b0, 1'b0, 8'(v));
      $display("vector and boundary test done");
      for (int i = 0; i < 64; i++) begin
         step(24'h000180 + 24'(2 * i), 1'b0, 1'b1, 8'h0c);
         step(24'h000180 + 24'(2 * i), 1'b1, 1'b0, 8'h11);
      end
      for (int i = 0; i < 64; i++) step(24'h000280 + 24'(2 * i), 1'b1, 1'b0, 8'(i));
      $display("register bank test done");
      for (int i = 0; i < 400; i++) begin
         k = $urandom % 8;
         a = 24'($urandom);
         if (k < 6) a[23:16] = bank[k];
         step(a, 1'($urandom), 1'b0, 8'($urandom % 144));
      end
      $display("random test done");
      @(negedge clk);
      flash_prog_mode = 1'b1;
      foreach (pm_a[i]) step(pm_a[i], 1'b1, 1'b0, 8'h8f);
      @(negedge clk);
      flash_prog_mode = 1'b0;
      $display("programming view test done");
      for (int i = 0; i < 4; i++) begin
         @(negedge clk);
         {operating_mode_pin, debug_if_pin} = 2'(i);
         age = 0;
         repeat (7) step(24'h0e9000, 1'b0, 1'b0, 8'h0b);
      end
      $display("mode pin test done");
      repeat (3) @(negedge clk);
      end_of_test;
   end
endmodule // amvd_decode_tb
`default_nettype wire
